// ===== rtl/charger_option_defines.svh
`ifndef CHARGER_OPTION_DEFINES_SVH
`define CHARGER_OPTION_DEFINES_SVH

// ----------------------------------------------------------------------
// register command codes
// ----------------------------------------------------------------------
`define CFG_ONE_ADDR 8'h30
`define CFG_TWO_ADDR 8'h31
`define CHARGE_CURRENT_ADDR 8'h14

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CFG_ONE_RESET 16'h0100
`define CFG_TWO_RESET 16'h00B7

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SHIP_BIT 1
`define WAKE_BIT 0
`define OVLD_SEL_HI 15
`define OVLD_SEL_LO 14
`define EN_OVERSHOOT_BIT 13
`define EN_DROOP_BIT 12
`define OVLD_FLAG_BIT 11
`define RELAX_FLAG_BIT 10
`define CYCLE_SEL_HI 9
`define CYCLE_SEL_LO 8

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_FREQ_KHZ 125000
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`TICK_PERIOD_US * `CLK_FREQ_KHZ) / 1000)
`define SHIP_WINDOW_MS 140
`define WAKE_LIMIT_MIN 30
`define WAKE_LIMIT_MS (`WAKE_LIMIT_MIN * 60 * 1000)
`define WAKE_CHARGE_MA 128
`define OVLD_T0_MS 1
`define OVLD_T1_MS 2
`define OVLD_T2_MS 5
`define OVLD_T3_MS 10
`define CYCLE_T0_MS 20
`define CYCLE_T1_MS 40
`define CYCLE_T2_MS 80
`define CYCLE_T3_MS 1000

`endif

// ===== rtl/charger_option_pkg.sv
package charger_option_pkg;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    surge_idle = 2'b00,
    surge_qualify = 2'b01,
    surge_overload = 2'b10,
    surge_relax = 2'b11
  } surge_phase_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [15:0] cfg_one;
    logic [15:0] cfg_two;
    surge_phase_e phase;
    logic [9:0] phase_cnt;
    logic [7:0] ship_cnt;
    logic ship_zero;
    logic [20:0] wake_cnt;
    logic wake_expired;
    logic [15:0] rdata;
    logic rvalid;
  } ctrl_state_s;

  typedef struct packed {
    logic [16:0] cnt;
    logic tick;
  } tick_state_s;

endpackage

// ===== rtl/ms_tick_gen.sv
`timescale 1ns/100ps
`include "charger_option_defines.svh"

module ms_tick_gen #(
  parameter logic [16:0] TICK_CYCLES = 17'(`TICK_CYCLES)
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic tick
);

  charger_option_pkg::tick_state_s state_reg;
  charger_option_pkg::tick_state_s state_next;

  // ----------------------------------------------------------------------
  // one pulse per millisecond
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.cnt >= TICK_CYCLES - 17'h00001)
    begin
      state_next.cnt = 17'h00000;
      state_next.tick = 1'b1;
    end
    else
    begin
      state_next.cnt = state_reg.cnt + 17'h00001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule

// ===== rtl/charger_option_control_bits.sv
// Functional notes
// - ship discharge runs 140 ms window, then bit clears itself.
// - host clearing ship bit early stops discharge immediately.
// - discharge current stops once negative sense pin reaches 0V.
// - wake bit with battery below minimum gives 128 mA charge, up to 30 min.
// - battery rising above minimum ends wake charging and clears wake bit, unless the 30 min limit has already expired.
// - any host write to charge current register 0x14 ends wake charging.
// - bits 15-14 select overload time 1, 2, 5 or 10 ms.
// - bit 13 enables surge mode on input current overshoot.
// - bit 12 enables surge mode on system voltage droop.
// - both enables zero keeps surge mode fully disabled.
// - adapter removal clears both surge enables.
// - overload flag reads 1 in overload phase; writing 0 exits it.
// - relax flag reads 1 in relax phase; writing 0 exits it.
// - bits 9-8 select cycle time 20, 40, 80 ms or 1 s.
`timescale 1ns/100ps
`include "charger_option_defines.svh"

module charger_option_control_bits #(
  parameter logic [16:0] TICK_CYCLES = 17'(`TICK_CYCLES),
  parameter logic [20:0] WAKE_LIMIT_MS = 21'(`WAKE_LIMIT_MS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire charger_option_pkg::reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sense_negative_at_zero,
  input wire logic battery_below_minimum,
  input wire logic adapter_present,
  input wire logic input_overshoot,
  input wire logic system_droop,
  output logic ship_discharge_on,
  output logic wake_charge_on,
  output logic surge_overload_active,
  output logic surge_relax_active
);

  charger_option_pkg::ctrl_state_s state_reg;
  charger_option_pkg::ctrl_state_s state_next;
  logic tick;

  // ----------------------------------------------------------------------
  // time decoders
  // ----------------------------------------------------------------------
  function automatic logic [9:0] overload_ms(input logic [1:0] sel);
    case (sel)
      2'h0: overload_ms = 10'(`OVLD_T0_MS);
      2'h1: overload_ms = 10'(`OVLD_T1_MS);
      2'h2: overload_ms = 10'(`OVLD_T2_MS);
      default: overload_ms = 10'(`OVLD_T3_MS);
    endcase
  endfunction

  function automatic logic [9:0] cycle_ms(input logic [1:0] sel);
    case (sel)
      2'h0: cycle_ms = 10'(`CYCLE_T0_MS);
      2'h1: cycle_ms = 10'(`CYCLE_T1_MS);
      2'h2: cycle_ms = 10'(`CYCLE_T2_MS);
      default: cycle_ms = 10'(`CYCLE_T3_MS);
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // millisecond timebase
  // ----------------------------------------------------------------------
  ms_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic wr_one;
    logic wr_two;
    logic wr_current;
    logic trigger;
    logic [1:0] ovld_sel;
    logic [1:0] cycle_sel;
    logic [15:0] cfg_two_view;
    wr_one = reg_req.wr && (reg_req.cmd == `CFG_ONE_ADDR);
    wr_two = reg_req.wr && (reg_req.cmd == `CFG_TWO_ADDR);
    wr_current = reg_req.wr && (reg_req.cmd == `CHARGE_CURRENT_ADDR);
    trigger = 1'b0;
    ovld_sel = 2'h0;
    cycle_sel = 2'h0;
    cfg_two_view = 16'h0000;
    state_next = state_reg;

    // ----------------------------------------------------------------------
    // ship discharge window
    // ----------------------------------------------------------------------
    if (state_reg.cfg_one[`SHIP_BIT])
    begin
      if (tick)
      begin
        state_next.ship_cnt = state_reg.ship_cnt + 8'h01;
      end
      if (sense_negative_at_zero)
      begin
        state_next.ship_zero = 1'b1;
      end
      if (tick && (state_reg.ship_cnt >= 8'(`SHIP_WINDOW_MS - 1)))
      begin
        state_next.cfg_one[`SHIP_BIT] = 1'b0;
      end
    end

    // ----------------------------------------------------------------------
    // wake charging
    // ----------------------------------------------------------------------
    if (state_reg.cfg_one[`WAKE_BIT] && !state_reg.wake_expired)
    begin
      if (battery_below_minimum)
      begin
        if (tick)
        begin
          state_next.wake_cnt = state_reg.wake_cnt + 21'h000001;
          if (state_reg.wake_cnt >= WAKE_LIMIT_MS - 21'h000001)
          begin
            state_next.wake_expired = 1'b1;
          end
        end
      end
      else
      begin
        state_next.cfg_one[`WAKE_BIT] = 1'b0;
      end
    end
    if (wr_current)
    begin
      state_next.cfg_one[`WAKE_BIT] = 1'b0;
    end

    // ----------------------------------------------------------------------
    // host writes to config one; a write of 1 wins over self clear
    // ----------------------------------------------------------------------
    if (wr_one)
    begin
      state_next.cfg_one = reg_req.wdata;
      if (reg_req.wdata[`SHIP_BIT])
      begin
        state_next.ship_cnt = 8'h00;
        state_next.ship_zero = sense_negative_at_zero;
      end
      if (reg_req.wdata[`WAKE_BIT])
      begin
        state_next.wake_cnt = 21'h000000;
        state_next.wake_expired = 1'b0;
      end
    end
    if (!state_next.cfg_one[`SHIP_BIT])
    begin
      state_next.ship_cnt = 8'h00;
      state_next.ship_zero = 1'b0;
    end
    if (!state_next.cfg_one[`WAKE_BIT])
    begin
      state_next.wake_cnt = 21'h000000;
      state_next.wake_expired = 1'b0;
    end

    // ----------------------------------------------------------------------
    // host writes to config two; status bits are not stored
    // ----------------------------------------------------------------------
    if (wr_two)
    begin
      state_next.cfg_two = reg_req.wdata;
      state_next.cfg_two[`OVLD_FLAG_BIT] = 1'b0;
      state_next.cfg_two[`RELAX_FLAG_BIT] = 1'b0;
    end
    if (!adapter_present)
    begin
      state_next.cfg_two[`EN_OVERSHOOT_BIT] = 1'b0;
      state_next.cfg_two[`EN_DROOP_BIT] = 1'b0;
    end

    // ----------------------------------------------------------------------
    // surge phase sequencer
    // ----------------------------------------------------------------------
    ovld_sel = state_reg.cfg_two[`OVLD_SEL_HI:`OVLD_SEL_LO];
    cycle_sel = state_reg.cfg_two[`CYCLE_SEL_HI:`CYCLE_SEL_LO];
    trigger = (state_reg.cfg_two[`EN_OVERSHOOT_BIT] && input_overshoot)
      || (state_reg.cfg_two[`EN_DROOP_BIT] && system_droop);
    if (tick)
    begin
      state_next.phase_cnt = state_reg.phase_cnt + 10'h001;
    end
    case (state_reg.phase)
      charger_option_pkg::surge_idle:
      begin
        state_next.phase_cnt = 10'h000;
        if (trigger)
        begin
          state_next.phase = charger_option_pkg::surge_qualify;
        end
      end
      charger_option_pkg::surge_qualify:
      begin
        if (!trigger)
        begin
          state_next.phase = charger_option_pkg::surge_idle;
        end
        else if (tick && (state_reg.phase_cnt >= overload_ms(ovld_sel) - 10'h001))
        begin
          state_next.phase = charger_option_pkg::surge_overload;
          state_next.phase_cnt = 10'h000;
        end
      end
      charger_option_pkg::surge_overload:
      begin
        if (wr_two && !reg_req.wdata[`OVLD_FLAG_BIT])
        begin
          state_next.phase = charger_option_pkg::surge_idle;
        end
        else if (tick && (state_reg.phase_cnt >= cycle_ms(cycle_sel) - 10'h001))
        begin
          state_next.phase = charger_option_pkg::surge_relax;
          state_next.phase_cnt = 10'h000;
        end
      end
      charger_option_pkg::surge_relax:
      begin
        if (wr_two && !reg_req.wdata[`RELAX_FLAG_BIT])
        begin
          state_next.phase = charger_option_pkg::surge_idle;
        end
        else if (tick && (state_reg.phase_cnt >= cycle_ms(cycle_sel) - 10'h001))
        begin
          state_next.phase = charger_option_pkg::surge_idle;
        end
      end
      default:
      begin
        state_next.phase = charger_option_pkg::surge_idle;
      end
    endcase
    if (!state_next.cfg_two[`EN_OVERSHOOT_BIT] && !state_next.cfg_two[`EN_DROOP_BIT])
    begin
      state_next.phase = charger_option_pkg::surge_idle;
    end
    if (state_next.phase == charger_option_pkg::surge_idle)
    begin
      state_next.phase_cnt = 10'h000;
    end

    // ----------------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------------
    cfg_two_view = state_reg.cfg_two;
    cfg_two_view[`OVLD_FLAG_BIT] = (state_reg.phase == charger_option_pkg::surge_overload);
    cfg_two_view[`RELAX_FLAG_BIT] = (state_reg.phase == charger_option_pkg::surge_relax);
    state_next.rvalid = reg_req.rd;
    if (reg_req.rd)
    begin
      case (reg_req.cmd)
        `CFG_ONE_ADDR: state_next.rdata = state_reg.cfg_one;
        `CFG_TWO_ADDR: state_next.rdata = cfg_two_view;
        default: state_next.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.cfg_one <= `CFG_ONE_RESET;
      state_reg.cfg_two <= `CFG_TWO_RESET;
      state_reg.phase <= charger_option_pkg::surge_idle;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;
  assign ship_discharge_on = state_reg.cfg_one[`SHIP_BIT] && !state_reg.ship_zero;
  // request for the fixed 128 mA wake charge current
  assign wake_charge_on = state_reg.cfg_one[`WAKE_BIT] && !state_reg.wake_expired
    && battery_below_minimum;
  assign surge_overload_active = (state_reg.phase == charger_option_pkg::surge_overload);
  assign surge_relax_active = (state_reg.phase == charger_option_pkg::surge_relax);

endmodule

// ===== tb/smbus_host_model.sv
`timescale 1ns/100ps

// --------------------------------------------------
// host side of the register port
// --------------------------------------------------
module smbus_host_model (
  input wire logic mclk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output charger_option_pkg::reg_req_s reg_req
);
  initial reg_req = '0;

  // idle bus shows inverted command and data, never the last value
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{1'b1, 1'b0, cmd, d};
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b0, ~cmd, ~d};
    #1;
  endtask

  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b1, cmd, ~reg_req.wdata};
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b0, ~cmd, ~reg_req.wdata};
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask
endmodule

// ===== tb/charger_option_control_bits_props.sv
`timescale 1ns/100ps
`include "charger_option_defines.svh"

// --------------------------------------------------
// port checker
// --------------------------------------------------
module charger_option_checker #(
  parameter logic [16:0] TICK_CYCLES = 17'(`TICK_CYCLES),
  parameter logic [20:0] WAKE_LIMIT_MS = 21'(`WAKE_LIMIT_MS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire charger_option_pkg::reg_req_s reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sense_negative_at_zero,
  input wire logic battery_below_minimum,
  input wire logic adapter_present,
  input wire logic input_overshoot,
  input wire logic system_droop,
  input wire logic ship_discharge_on,
  input wire logic wake_charge_on,
  input wire logic surge_overload_active,
  input wire logic surge_relax_active
);
  localparam longint SHIP_MAX = 140 * longint'(TICK_CYCLES) + 2;
  localparam longint WAKE_MAX = longint'(WAKE_LIMIT_MS) * longint'(TICK_CYCLES) + 2;
  logic wr_one;
  logic wr_two;
  longint ship_run;
  longint wake_run;
  assign wr_one = reg_req.wr && reg_req.cmd == 8'h30;
  assign wr_two = reg_req.wr && reg_req.cmd == 8'h31;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // lengths of uninterrupted discharge and wake charge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ship_run <= 64'h0;
      wake_run <= 64'h0;
    end
    else
    begin
      ship_run <= (!ship_discharge_on || wr_one) ? 64'h0 : ship_run + 1;
      wake_run <= (!wake_charge_on || wr_one) ? 64'h0 : wake_run + 1;
    end
  end

  chk_rd_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("answer without read");
  chk_ship_window: assert property (ship_run <= SHIP_MAX)
    else $error("discharge too long");
  chk_ship_host_stop: assert property (wr_one && !reg_req.wdata[1] |=> !ship_discharge_on)
    else $error("discharge not stopped");
  chk_ship_zero_stop: assert property (ship_discharge_on && sense_negative_at_zero
    && !wr_one |=> !ship_discharge_on)
    else $error("discharge past zero");
  chk_wake_low_batt: assert property ($past(wake_charge_on) && !battery_below_minimum
    && !wr_one |=> !wake_charge_on)
    else $error("wake bit not cleared");
  chk_wake_limit: assert property (wake_run <= WAKE_MAX)
    else $error("wake charge too long");
  chk_wake_exit_cmd: assert property (reg_req.wr && reg_req.cmd == 8'h14 |=> !wake_charge_on)
    else $error("wake charge not ended");
  chk_surge_adapter: assert property (!adapter_present
    |=> !surge_overload_active && !surge_relax_active)
    else $error("surge without adapter");
  chk_surge_disabled: assert property (wr_two && reg_req.wdata[13:12] == 2'b00
    |=> !surge_overload_active && !surge_relax_active)
    else $error("surge with both enables clear");
  chk_relax_order: assert property ($rose(surge_relax_active) |-> $past(surge_overload_active))
    else $error("relax without overload");
  chk_ovld_exit: assert property (wr_two && !reg_req.wdata[11] && surge_overload_active
    |=> !surge_overload_active)
    else $error("overload not left");
  chk_relax_exit: assert property (wr_two && !reg_req.wdata[10] && surge_relax_active
    |=> !surge_relax_active)
    else $error("relax not left");

  cov_ship_end: cover property ($fell(ship_discharge_on));
  cov_ovld: cover property ($rose(surge_overload_active));
  cov_relax_end: cover property ($fell(surge_relax_active));
endmodule

bind charger_option_control_bits charger_option_checker #(
  .TICK_CYCLES(TICK_CYCLES), .WAKE_LIMIT_MS(WAKE_LIMIT_MS)
) chk (
  .mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .sense_negative_at_zero(sense_negative_at_zero),
  .battery_below_minimum(battery_below_minimum), .adapter_present(adapter_present),
  .input_overshoot(input_overshoot), .system_droop(system_droop),
  .ship_discharge_on(ship_discharge_on), .wake_charge_on(wake_charge_on),
  .surge_overload_active(surge_overload_active), .surge_relax_active(surge_relax_active)
);

// ===== tb/charger_option_control_bits_test.sv
`timescale 1ns/100ps
`include "charger_option_defines.svh"

// --------------------------------------------------
// register-level test
// --------------------------------------------------
module charger_option_control_bits_test;
  localparam int T = 4;
  localparam int TOV[4] = '{1, 2, 5, 10};
  localparam int TCY[4] = '{20, 40, 80, 1000};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic at_zero = 1'b0;
  logic batt_low = 1'b0;
  logic adapter = 1'b1;
  logic overshoot = 1'b0;
  logic droop = 1'b0;
  charger_option_pkg::reg_req_s req;
  logic [15:0] rdata;
  logic [15:0] got;
  logic rvalid;
  wire [3:0] outs;
  int n_fail = 0;
  int checked = 0;
  int n;

  always #4 mclk = ~mclk;

  smbus_host_model host (.mclk(mclk), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_req(req));

  charger_option_control_bits #(.TICK_CYCLES(17'(T)), .WAKE_LIMIT_MS(21'd5)) dut (
    .mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .sense_negative_at_zero(at_zero), .battery_below_minimum(batt_low),
    .adapter_present(adapter), .input_overshoot(overshoot), .system_droop(droop),
    .ship_discharge_on(outs[0]), .wake_charge_on(outs[1]),
    .surge_overload_active(outs[2]), .surge_relax_active(outs[3])
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic in_range(input int v, input int lo, input int hi);
    check(32'((v >= lo && v <= hi) ? 0 : v), 32'h0);
  endtask

  task automatic close_out;
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  // waits for one output to reach a level, counting cycles
  task automatic wait_lvl(input int k, input logic lvl, output int c);
    c = 0;
    while (outs[k] !== lvl && c < 9000)
    begin
      @(posedge mclk);
      #1;
      c++;
    end
    if (c >= 9000)
    begin
      check(c, 0);
      close_out();
    end
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    host.rd(`CFG_ONE_ADDR, got);
    check(got, `CFG_ONE_RESET);
    host.rd(`CFG_TWO_ADDR, got);
    check(got, `CFG_TWO_RESET);
    host.wr(8'h20, 16'hFFFF);
    host.rd(8'h20, got);
    check(got, 16'h0000);
    // ship discharge: full window, early stop, zero pin, restart
    host.wr(`CFG_ONE_ADDR, 16'h0102);
    check(outs[0], 1'b1);
    wait_lvl(0, 1'b0, n);
    in_range(n, 139 * T - 2, 140 * T + 1);
    host.rd(`CFG_ONE_ADDR, got);
    check(got, 16'h0100);
    host.wr(`CFG_ONE_ADDR, 16'h0102);
    idle(10);
    host.wr(`CFG_ONE_ADDR, 16'h0100);
    check(outs[0], 1'b0);
    host.wr(`CFG_ONE_ADDR, 16'h0102);
    idle(20);
    @(posedge mclk) at_zero <= 1'b1;
    idle(2);
    check(outs[0], 1'b0);
    @(posedge mclk) at_zero <= 1'b0;
    idle(2);
    check(outs[0], 1'b0);
    host.wr(`CFG_ONE_ADDR, 16'h0102);
    check(outs[0], 1'b1);
    wait_lvl(0, 1'b0, n);
    in_range(n, 139 * T - 2, 140 * T + 1);
    // wake charge: register write exit, battery recovery, time limit
    @(posedge mclk) batt_low <= 1'b1;
    host.wr(`CFG_ONE_ADDR, 16'h0101);
    check(outs[1], 1'b1);
    host.wr(`CHARGE_CURRENT_ADDR, 16'h0200);
    check(outs[1], 1'b0);
    host.rd(`CFG_ONE_ADDR, got);
    check(got, 16'h0100);
    host.wr(`CFG_ONE_ADDR, 16'h0101);
    @(posedge mclk) batt_low <= 1'b0;
    idle(2);
    host.rd(`CFG_ONE_ADDR, got);
    check(got, 16'h0100);
    @(posedge mclk) batt_low <= 1'b1;
    host.wr(`CFG_ONE_ADDR, 16'h0101);
    wait_lvl(1, 1'b0, n);
    in_range(n, 4 * T - 2, 5 * T + 1);
    host.rd(`CFG_ONE_ADDR, got);
    check(got, 16'h0101);
    // surge phases over every overload and cycle time code
    for (int i = 0; i < 4; i++)
    begin
      host.wr(`CFG_TWO_ADDR, {2'(i), 4'h8, 2'(i), 8'hB7});
      @(posedge mclk) overshoot <= 1'b1;
      wait_lvl(2, 1'b1, n);
      in_range(n, (TOV[i] - 1) * T - 2, TOV[i] * T + 3);
      host.rd(`CFG_TWO_ADDR, got);
      check(got, {2'(i), 4'hA, 2'(i), 8'hB7});
      wait_lvl(3, 1'b1, n);
      in_range(n + 2, (TCY[i] - 1) * T - 2, TCY[i] * T + 3);
      host.rd(`CFG_TWO_ADDR, got);
      check(got, {2'(i), 4'h9, 2'(i), 8'hB7});
      @(posedge mclk) overshoot <= 1'b0;
      wait_lvl(3, 1'b0, n);
      in_range(n + 3, (TCY[i] - 1) * T - 2, TCY[i] * T + 3);
    end
    // each trigger ignored while its own enable is clear
    host.wr(`CFG_TWO_ADDR, 16'h10B7);
    @(posedge mclk) overshoot <= 1'b1;
    idle(40);
    check(outs[3:2], 2'b00);
    @(posedge mclk) overshoot <= 1'b0;
    host.wr(`CFG_TWO_ADDR, 16'h20B7);
    @(posedge mclk) droop <= 1'b1;
    idle(40);
    check(outs[3:2], 2'b00);
    // droop trigger and forced exits
    host.wr(`CFG_TWO_ADDR, 16'h10B7);
    @(posedge mclk) droop <= 1'b1;
    wait_lvl(2, 1'b1, n);
    check(outs[2], 1'b1);
    host.wr(`CFG_TWO_ADDR, 16'h10B7);
    check(outs[2], 1'b0);
    wait_lvl(3, 1'b1, n);
    host.wr(`CFG_TWO_ADDR, 16'h10B7);
    check(outs[3], 1'b0);
    @(posedge mclk) overshoot <= 1'b1;
    host.wr(`CFG_TWO_ADDR, 16'h00B7);
    idle(100);
    check(outs[3:2], 2'b00);
    host.wr(`CFG_TWO_ADDR, 16'h30B7);
    idle(8);
    @(posedge mclk) adapter <= 1'b0;
    idle(2);
    check(outs[3:2], 2'b00);
    host.rd(`CFG_TWO_ADDR, got);
    check(got, 16'h00B7);
    host.wr(`CFG_TWO_ADDR, 16'h30B7);
    host.rd(`CFG_TWO_ADDR, got);
    check(got, 16'h00B7);
    close_out();
  end
endmodule
